// ---- tb/testbench.sv ----
// Self-checking bench for the slave status register group
`timescale 1ns/10ps
module testbench;
    import usbsr_pkg::*;
    logic       clk_sys_i, rstn_i, cs_n, wr_n, rd_n, a0;
    logic       bus_rst, sof, dma_byte;
    logic [7:0] bus_d, rdata, token_addr, v;
    logic [3:0] ep_done, pingpong;
    logic [10:0] frame_num;
    logic       irq, match, role, swap, dir, active;
    logic       oe, oe_exp;
    logic [5:0] outs;
    int         mismatches = 0;
    int         num_checks = 0;
    logic [7:0] regs [5] = '{8'h07, 8'h0d, 8'h0f, 8'h35, 8'h36};

    assign outs = {irq, active, dir, match, role, swap};

    usbsr_cpu_model cpu (.clk_sys_i(clk_sys_i), .cs_n_o(cs_n), .wr_n_o(wr_n), .rd_n_o(rd_n),
        .a0_o(a0), .data_o(bus_d), .rdata_i(rdata));

    usbsr_regs dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cs_n_i(cs_n), .wr_n_i(wr_n),
        .rd_n_i(rd_n), .a0_i(a0), .data_i(bus_d), .data_o(rdata), .data_oe_o(oe),
        .interrupt_request_out_o(irq), .bus_reset_evt_i(bus_rst), .sof_evt_i(sof),
        .frame_num_i(frame_num), .ep_done_i(ep_done), .pingpong_i(pingpong),
        .token_addr_i(token_addr), .dma_byte_i(dma_byte), .addr_match_o(match),
        .host_role_o(role), .polarity_swap_o(swap), .dma_read_dir_o(dir),
        .dma_active_o(active));

    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    // Output enable trails the strobe by one edge; compared mid-cycle where it is settled
    always @(posedge clk_sys_i) begin
        oe_exp <= !cs_n && !rd_n;
    end

    always @(negedge clk_sys_i) begin
        if (rstn_i)
            chk({7'h00, oe}, {7'h00, oe_exp});
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] q;
        cpu.rd(addr, q);
        chk(q, exp);
    endtask

    // Output pins are registered, so let two edges settle before looking
    task automatic ochk(input logic [5:0] mask, input logic [5:0] exp);
        tick(2);
        chk({2'b00, outs & mask}, {2'b00, exp});
    endtask

    task automatic bytes(input int n);
        repeat (n) begin
            dma_byte = 1'b1;
            tick(1);
            dma_byte = 1'b0;
            tick(1);
        end
    endtask

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        #200000;
        mismatches++;
        end_of_test();
    end

    initial begin
        {rstn_i, bus_rst, sof, dma_byte} = 4'h0;
        {ep_done, pingpong, token_addr} = {4'h0, 4'ha, 8'h00};
        frame_num = 11'h5a3;
        tick(3);
        rstn_i = 1'b1;
        tick(1);
        foreach (regs[i]) rchk(regs[i], 8'h00);
        cpu.wr(8'h07, 8'ha5);
        rchk(8'h07, 8'ha5);
        token_addr = 8'ha5;
        ochk(6'h0c, 6'h04);
        token_addr = 8'ha4;
        ochk(6'h04, 6'h00);
        cpu.wr(8'h0f, 8'hff);
        rchk(8'h0f, 8'hc0);
        ochk(6'h03, 6'h03);
        cpu.wr(8'h0f, 8'h40);
        ochk(6'h03, 6'h01);
        cpu.wr(8'h0e, 8'hff);
        rchk(8'h0e, 8'h0a);
        $display("test address and control done");
        {bus_rst, sof, ep_done} = {2'b11, 4'h7};
        tick(1);
        {bus_rst, sof, ep_done} = {2'b00, 4'h8};
        tick(1);
        {ep_done, frame_num} = {4'h0, 11'h000};
        rchk(8'h0d, 8'h67);
        rchk(8'h15, 8'h46);
        cpu.rd(8'h16, v);
        chk(v & 8'hf0, 8'hb0);
        cpu.wr(8'h06, 8'h20);
        ochk(6'h20, 6'h20);
        rchk(8'h0d, 8'h67);
        cpu.wr(8'h0d, 8'h20);
        rchk(8'h0d, 8'h47);
        ochk(6'h20, 6'h00);
        cpu.wr(8'h0d, 8'h00);
        rchk(8'h0d, 8'h47);
        {sof, frame_num} = {1'b1, 11'h0ff};
        tick(1);
        sof = 1'b0;
        rchk(8'h15, 8'hfe);
        cpu.rd(8'h16, v);
        chk(v & 8'hf0, 8'h10);
        cpu.wr(8'h0d, 8'hff);
        rchk(8'h0d, 8'h00);
        $display("test event flags done");
        cpu.wr(8'h06, 8'h80);
        cpu.wr(8'h35, 8'h01);
        cpu.wr(8'h36, 8'h00);
        ochk(6'h10, 6'h00);
        cpu.wr(8'h05, 8'h06);
        ochk(6'h08, 6'h08);
        cpu.wr(8'h35, 8'h02);
        cpu.wr(8'h36, 8'h01);
        ochk(6'h10, 6'h10);
        rchk(8'h0d, 8'h80);
        rchk(8'h35, 8'h02);
        rchk(8'h36, 8'h01);
        ep_done = 4'h8;
        tick(1);
        ep_done = 4'h0;
        bytes(257);
        ochk(6'h10, 6'h10);
        bytes(1);
        ochk(6'h30, 6'h00);
        rchk(8'h0d, 8'h18);
        ochk(6'h20, 6'h00);
        cpu.wr(8'h06, 8'h10);
        ochk(6'h20, 6'h20);
        $display("test dma count done");
        end_of_test();
    end
endmodule

// ---- tb/usbsr_cpu_model.sv ----
// Processor model driving the register group's 8-bit parallel port
`timescale 1ns/10ps
module usbsr_cpu_model (
    // Clock
    input  wire logic       clk_sys_i,
    // Parallel port toward the register group
    output logic            cs_n_o,
    output logic            wr_n_o,
    output logic            rd_n_o,
    output logic            a0_o,
    output logic [7:0]      data_o,
    input  wire logic [7:0] rdata_i
);
    initial begin
        {cs_n_o, wr_n_o, rd_n_o, a0_o} = 4'b1110;
        data_o = 8'h00;
    end

    // One strobe; called just after a rising edge, returns one edge after release
    task automatic cycle(input logic a0, input logic rd, input logic [7:0] d,
                         output logic [7:0] q);
        {cs_n_o, wr_n_o, rd_n_o, a0_o} = {1'b0, rd, ~rd, a0};
        data_o = d;
        @(posedge clk_sys_i);
        if (rd) @(posedge clk_sys_i);
        #1 q = rdata_i;
        {cs_n_o, wr_n_o, rd_n_o} = 3'b111;
        // Released bus shows the inverse so a stale value never looks valid
        data_o = ~d;
        @(posedge clk_sys_i);
        #1;
    endtask

    // Pointer write first, then the data access
    task automatic wr(input logic [7:0] addr, input logic [7:0] val);
        logic [7:0] q;
        cycle(1'b0, 1'b0, addr, q);
        cycle(1'b1, 1'b0, val, q);
    endtask

    task automatic rd(input logic [7:0] addr, output logic [7:0] val);
        logic [7:0] q;
        cycle(1'b0, 1'b0, addr, q);
        cycle(1'b1, 1'b1, ~addr, val);
    endtask
endmodule

// ---- verilog/usbsr_consts.svh ----
// Offsets, field positions and reset values for the slave status register group
`ifndef USBSR_CONSTS_SVH
`define USBSR_CONSTS_SVH

`define USBSR_OFF_CTRL1     8'h05
`define USBSR_OFF_INT_EN    8'h06
`define USBSR_OFF_DEV_ADDR  8'h07
`define USBSR_OFF_STATUS    8'h0d
`define USBSR_OFF_PINGPONG  8'h0e
`define USBSR_OFF_CTRL2     8'h0f
`define USBSR_OFF_FRAME_LO  8'h15
`define USBSR_OFF_FRAME_HI  8'h16
`define USBSR_OFF_CNT_LO    8'h35
`define USBSR_OFF_CNT_HI    8'h36

`define USBSR_BIT_DMA_RUN   7
`define USBSR_BIT_BUS_RST   6
`define USBSR_BIT_SOF       5
`define USBSR_BIT_DMA_DONE  4
`define USBSR_BIT_EP3       3
`define USBSR_BIT_DMA_DIR   2
`define USBSR_BIT_DMA_EN    1
`define USBSR_BIT_ROLE      7
`define USBSR_BIT_SWAP      6

`define USBSR_RST_BYTE      8'h00
`define USBSR_RST_CNT       16'h0000
`define USBSR_CTRL2_MASK    8'hc0
`define USBSR_EVT_MASK      8'h7f

`endif

// ---- verilog/usbsr_dma_ctr.sv ----
// DMA byte counter: runs from start until the programmed total has moved
`timescale 1ns/10ps
`include "usbsr_consts.svh"
module usbsr_dma_ctr (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rstn_i,
    // Control side
    usbsr_dma_if.ctr         dma
);
    import usbsr_pkg::*;
    usbsr_dma_state_type state_r, state_nxt;
    usbsr_count_type     cnt_r, cnt_nxt;
    logic                busy_r, busy_nxt;
    logic                done_r, done_nxt;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            USBSR_DMA_IDLE, USBSR_DMA_DONE: begin
                state_nxt = USBSR_DMA_IDLE;
                if (dma.start) begin
                    state_nxt = USBSR_DMA_RUN;
                    cnt_nxt   = `USBSR_RST_CNT;
                end
            end
            USBSR_DMA_RUN: begin
                // A high byte rewrite while running starts the count afresh
                if (dma.start) begin
                    cnt_nxt = `USBSR_RST_CNT;
                // A zero total ends at once, which matches count reaching total
                end else if (cnt_r == dma.total) begin
                    state_nxt = USBSR_DMA_DONE;
                end else if (dma.byte_done) begin
                    cnt_nxt = cnt_r + 16'h0001;
                end
            end
            default: state_nxt = USBSR_DMA_IDLE;
        endcase
        busy_nxt = (state_nxt == USBSR_DMA_RUN);
        done_nxt = (state_nxt == USBSR_DMA_DONE);
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= USBSR_DMA_IDLE;
            cnt_r   <= `USBSR_RST_CNT;
            busy_r  <= 1'b0;
            done_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            busy_r  <= busy_nxt;
            done_r  <= done_nxt;
        end
    end

    // Flags come from flip-flops so the running pin has no decode glitch
    assign dma.busy = busy_r;
    assign dma.done = done_r;
endmodule

// ---- verilog/usbsr_dma_if.sv ----
// Carrier between the register group and its DMA byte counter
`timescale 1ns/10ps
interface usbsr_dma_if;
    import usbsr_pkg::*;
    logic            start;
    logic            byte_done;
    usbsr_count_type total;
    logic            busy;
    logic            done;
    modport ctl (output start, output byte_done, output total, input busy, input done);
    modport ctr (input start, input byte_done, input total, output busy, output done);
endinterface

// ---- verilog/usbsr_pkg.sv ----
// Types shared by the slave status register group
package usbsr_pkg;
    typedef logic [7:0]  usbsr_byte_type;
    typedef logic [15:0] usbsr_count_type;
    typedef logic [10:0] usbsr_frame_type;
    typedef enum logic [1:0] {
        USBSR_DMA_IDLE = 2'b00,
        USBSR_DMA_RUN  = 2'b01,
        USBSR_DMA_DONE = 2'b10
    } usbsr_dma_state_type;
endpackage

// ---- verilog/usbsr_regs.sv ----
// Slave-mode register group: parallel port, event flags, frame number, DMA count
`timescale 1ns/10ps
`include "usbsr_consts.svh"
module usbsr_regs (
    // Clock and reset
    input  wire logic                clk_sys_i,
    input  wire logic                rstn_i,
    // Processor port
    input  wire logic                cs_n_i,
    input  wire logic                wr_n_i,
    input  wire logic                rd_n_i,
    input  wire logic                a0_i,
    input  wire usbsr_pkg::usbsr_byte_type  data_i,
    output logic [7:0]               data_o,
    output logic                     data_oe_o,
    output logic                     interrupt_request_out_o,
    // Serial engine side
    input  wire logic                bus_reset_evt_i,
    input  wire logic                sof_evt_i,
    input  wire usbsr_pkg::usbsr_frame_type frame_num_i,
    input  wire logic [3:0]          ep_done_i,
    input  wire logic [3:0]          pingpong_i,
    input  wire logic [7:0]          token_addr_i,
    input  wire logic                dma_byte_i,
    output logic                     addr_match_o,
    output logic                     host_role_o,
    output logic                     polarity_swap_o,
    output logic                     dma_read_dir_o,
    output logic                     dma_active_o
);
    import usbsr_pkg::*;

    usbsr_dma_if dma_bus ();

    usbsr_byte_type  ptr_r, ptr_nxt;
    usbsr_byte_type  ctrl1_r, ctrl1_nxt;
    usbsr_byte_type  int_en_r, int_en_nxt;
    usbsr_byte_type  dev_addr_r, dev_addr_nxt;
    logic [6:0]      flags_r, flags_nxt;
    usbsr_byte_type  ctrl2_r, ctrl2_nxt;
    usbsr_frame_type frame_r, frame_nxt;
    usbsr_count_type total_r, total_nxt;
    logic            wr_n_q_r, rd_n_q_r;
    usbsr_byte_type  dout_r, dout_nxt;
    logic            doe_r, doe_nxt;
    logic            irq_r, irq_nxt;
    logic            match_r, match_nxt;
    logic            start_r, start_nxt;
    logic            wr_edge, rd_edge, reg_wr;
    usbsr_byte_type  status_rd, rd_mux;
    logic [6:0]      evt_set, evt_clr;

    usbsr_dma_ctr u_ctr (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .dma       (dma_bus.ctr)
    );

    assign dma_bus.start     = start_r;
    assign dma_bus.byte_done = dma_byte_i;
    assign dma_bus.total     = total_r;

    // Strobes act on their falling edge so a long strobe counts once
    assign wr_edge = !cs_n_i && !wr_n_i && wr_n_q_r;
    assign rd_edge = !cs_n_i && !rd_n_i && rd_n_q_r;
    assign reg_wr  = wr_edge && a0_i;

    assign status_rd = {dma_bus.busy, flags_r};

    always_comb begin
        case (ptr_r)
            `USBSR_OFF_CTRL1:    rd_mux = ctrl1_r;
            `USBSR_OFF_INT_EN:   rd_mux = int_en_r;
            `USBSR_OFF_DEV_ADDR: rd_mux = dev_addr_r;
            `USBSR_OFF_STATUS:   rd_mux = status_rd;
            `USBSR_OFF_PINGPONG: rd_mux = {4'h0, pingpong_i};
            `USBSR_OFF_CTRL2:    rd_mux = ctrl2_r;
            `USBSR_OFF_FRAME_LO: rd_mux = {frame_r[6:0], 1'b0};
            `USBSR_OFF_FRAME_HI: rd_mux = {frame_r[10:7], 4'h0};
            `USBSR_OFF_CNT_LO:   rd_mux = total_r[7:0];
            `USBSR_OFF_CNT_HI:   rd_mux = total_r[15:8];
            default:             rd_mux = `USBSR_RST_BYTE;
        endcase
    end

    always_comb begin
        // Endpoint three only completes while DMA serves it
        evt_set = {bus_reset_evt_i, sof_evt_i, dma_bus.done,
                   ep_done_i[3] && dma_bus.busy, ep_done_i[2:0]};
        evt_clr = (reg_wr && ptr_r == `USBSR_OFF_STATUS) ? data_i[6:0] : 7'h00;
        ptr_nxt      = (wr_edge && !a0_i) ? data_i : ptr_r;
        ctrl1_nxt    = ctrl1_r;
        int_en_nxt   = int_en_r;
        dev_addr_nxt = dev_addr_r;
        ctrl2_nxt    = ctrl2_r;
        total_nxt    = total_r;
        start_nxt    = 1'b0;
        if (reg_wr) begin
            case (ptr_r)
                `USBSR_OFF_CTRL1:    ctrl1_nxt = {1'b0, data_i[6:0]};
                `USBSR_OFF_INT_EN:   int_en_nxt = data_i;
                `USBSR_OFF_DEV_ADDR: dev_addr_nxt = data_i;
                `USBSR_OFF_CTRL2:    ctrl2_nxt = data_i & `USBSR_CTRL2_MASK;
                `USBSR_OFF_CNT_LO:   total_nxt[7:0] = data_i;
                `USBSR_OFF_CNT_HI: begin
                    total_nxt[15:8] = data_i;
                    start_nxt = ctrl1_r[`USBSR_BIT_DMA_EN];
                end
                default: ctrl1_nxt = ctrl1_r;
            endcase
        end
        // Set beats a clear in the same cycle so no event is lost
        flags_nxt = (flags_r & ~evt_clr) | evt_set;
        frame_nxt = sof_evt_i ? frame_num_i : frame_r;
        dout_nxt  = rd_edge ? rd_mux : dout_r;
        doe_nxt   = !cs_n_i && !rd_n_i;
        // Running bit 7 is left out of the request on purpose
        irq_nxt   = |(flags_nxt & int_en_nxt[6:0]);
        match_nxt = (token_addr_i == dev_addr_r);
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ptr_r      <= `USBSR_RST_BYTE;
            ctrl1_r    <= `USBSR_RST_BYTE;
            int_en_r   <= `USBSR_RST_BYTE;
            dev_addr_r <= `USBSR_RST_BYTE;
            flags_r    <= 7'h00;
            ctrl2_r    <= `USBSR_RST_BYTE;
            frame_r    <= 11'h000;
            total_r    <= `USBSR_RST_CNT;
            wr_n_q_r   <= 1'b1;
            rd_n_q_r   <= 1'b1;
            dout_r     <= `USBSR_RST_BYTE;
            doe_r      <= 1'b0;
            irq_r      <= 1'b0;
            match_r    <= 1'b0;
            start_r    <= 1'b0;
        end else begin
            ptr_r      <= ptr_nxt;
            ctrl1_r    <= ctrl1_nxt;
            int_en_r   <= int_en_nxt;
            dev_addr_r <= dev_addr_nxt;
            flags_r    <= flags_nxt;
            ctrl2_r    <= ctrl2_nxt;
            frame_r    <= frame_nxt;
            total_r    <= total_nxt;
            wr_n_q_r   <= wr_n_i | cs_n_i;
            rd_n_q_r   <= rd_n_i | cs_n_i;
            dout_r     <= dout_nxt;
            doe_r      <= doe_nxt;
            irq_r      <= irq_nxt;
            match_r    <= match_nxt;
            start_r    <= start_nxt;
        end
    end

    // Control outputs come from their registers directly
    assign data_o                  = dout_r;
    assign data_oe_o               = doe_r;
    assign interrupt_request_out_o = irq_r;
    assign addr_match_o            = match_r;
    assign host_role_o             = ctrl2_r[`USBSR_BIT_ROLE];
    assign polarity_swap_o         = ctrl2_r[`USBSR_BIT_SWAP];
    assign dma_read_dir_o          = ctrl1_r[`USBSR_BIT_DMA_DIR];
    assign dma_active_o            = dma_bus.busy;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    sequence s_hi_write_en;
        reg_wr && ptr_r == `USBSR_OFF_CNT_HI && ctrl1_r[`USBSR_BIT_DMA_EN];
    endsequence

    sequence s_run_then_done;
        dma_bus.busy ##1 !dma_bus.busy && dma_bus.done;
    endsequence

    sequence s_read_of(logic [7:0] off);
        rd_edge && ptr_r == off;
    endsequence

    a_clear_one_flag: assert property (
        reg_wr && ptr_r == `USBSR_OFF_STATUS && data_i[0] && !ep_done_i[0]
        |=> !flags_r[0]) else $error("status write of one did not clear flag");
    a_zero_keeps_flag: assert property (
        reg_wr && ptr_r == `USBSR_OFF_STATUS && !data_i[4] && flags_r[4]
        |=> flags_r[4]) else $error("status write of zero lost a flag");
    a_dma_start_run: assert property (
        s_hi_write_en |-> ##2 dma_bus.busy) else $error("count high write did not start DMA");
    a_no_start_off: assert property (
        reg_wr && ptr_r == `USBSR_OFF_CNT_HI && !ctrl1_r[`USBSR_BIT_DMA_EN]
        && !dma_bus.busy |-> ##2 !dma_bus.busy) else $error("DMA started while disabled");
    a_done_sets_flag: assert property (
        s_run_then_done |=> flags_r[4]) else $error("DMA end did not set done flag");
    a_status_bit_run: assert property (
        s_read_of(`USBSR_OFF_STATUS)
        |=> data_o[7] == $past(dma_bus.busy)) else $error("status bit 7 not tracking DMA");
    a_irq_follows_en: assert property (
        |(flags_r & int_en_r[6:0]) |-> irq_r) else $error("enabled flag without request");
    a_irq_quiet_run: assert property (
        !(|(flags_r & int_en_r[6:0])) |-> !irq_r) else $error("request without enabled flag");
    a_frame_reload: assert property (
        sof_evt_i |=> frame_r == $past(frame_num_i)) else $error("frame number not reloaded");
    a_addr_reset: assert property (
        $rose(rstn_i) |-> dev_addr_r == `USBSR_RST_BYTE) else $error("address not zero");
    a_ctrl2_reserved: assert property (
        reg_wr && ptr_r == `USBSR_OFF_CTRL2
        |=> ctrl2_r[5:0] == 6'h00) else $error("reserved control bits set");

    // Control writes land in the bits that drive the pins
    a_role_host_set: assert property (
        reg_wr && ptr_r == `USBSR_OFF_CTRL2 && data_i[`USBSR_BIT_ROLE]
        |=> host_role_o) else $error("host role not set");
    a_role_slave_set: assert property (
        reg_wr && ptr_r == `USBSR_OFF_CTRL2 && !data_i[`USBSR_BIT_ROLE]
        |=> !host_role_o) else $error("slave role not set");
    a_swap_write: assert property (
        reg_wr && ptr_r == `USBSR_OFF_CTRL2 && data_i[`USBSR_BIT_SWAP]
        |=> polarity_swap_o) else $error("polarity swap not set");
    a_dir_read_set: assert property (
        reg_wr && ptr_r == `USBSR_OFF_CTRL1 && data_i[`USBSR_BIT_DMA_DIR]
        |=> dma_read_dir_o) else $error("DMA read direction not set");
    a_dir_write_set: assert property (
        reg_wr && ptr_r == `USBSR_OFF_CTRL1 && !data_i[`USBSR_BIT_DMA_DIR]
        |=> !dma_read_dir_o) else $error("DMA write direction not set");
    a_ctrl1_top_zero: assert property (
        reg_wr && ptr_r == `USBSR_OFF_CTRL1
        |=> !ctrl1_r[7]) else $error("control bit 7 set");

    // Read data stands one edge after the read strobe is taken
    a_status_read_flags: assert property (
        s_read_of(`USBSR_OFF_STATUS)
        |=> data_o[6:0] == $past(flags_r)) else $error("status read lost flags");
    a_pingpong_read: assert property (
        s_read_of(`USBSR_OFF_PINGPONG)
        |=> data_o == {4'h0, $past(pingpong_i)}) else $error("buffer select read wrong");
    a_frame_low_read: assert property (
        rd_edge && ptr_r == `USBSR_OFF_FRAME_LO && !sof_evt_i
        |=> data_o[7:1] == frame_r[6:0]) else $error("frame low read wrong");
    a_frame_high_read: assert property (
        rd_edge && ptr_r == `USBSR_OFF_FRAME_HI && !sof_evt_i
        |=> data_o[7:4] == frame_r[10:7]) else $error("frame high read wrong");
    a_addr_read: assert property (
        s_read_of(`USBSR_OFF_DEV_ADDR)
        |=> data_o == $past(dev_addr_r)) else $error("address read wrong");
    a_cnt_low_read: assert property (
        rd_edge && !wr_edge && ptr_r == `USBSR_OFF_CNT_LO
        |=> data_o == total_r[7:0]) else $error("count low read wrong");
    a_cnt_high_read: assert property (
        rd_edge && !wr_edge && ptr_r == `USBSR_OFF_CNT_HI
        |=> data_o == total_r[15:8]) else $error("count high read wrong");
    a_unmapped_zero: assert property (
        s_read_of(8'h00) |=> data_o == 8'h00) else $error("unmapped read not zero");

    // Writes land at the pointer one edge after the strobe is taken
    a_ptr_load: assert property (
        wr_edge && !a0_i |=> ptr_r == $past(data_i)) else $error("pointer not loaded");
    a_strobe_once: assert property (
        wr_edge |=> !wr_edge) else $error("write strobe counted twice");
    a_addr_write: assert property (
        reg_wr && ptr_r == `USBSR_OFF_DEV_ADDR
        |=> dev_addr_r == $past(data_i)) else $error("address write lost");
    a_cnt_low_write: assert property (
        reg_wr && ptr_r == `USBSR_OFF_CNT_LO
        |=> total_r[7:0] == $past(data_i)) else $error("count low write lost");
    a_cnt_high_write: assert property (
        reg_wr && ptr_r == `USBSR_OFF_CNT_HI
        |=> total_r[15:8] == $past(data_i)) else $error("count high write lost");
    a_enable_no_status: assert property (
        reg_wr && ptr_r == `USBSR_OFF_INT_EN && evt_set == 7'h00
        |=> flags_r == $past(flags_r)) else $error("enable write altered status");

    // Each event leaves its flag pending on the next edge; endpoint three sets its flag only while DMA is running
    a_bus_reset_flag: assert property (
        bus_reset_evt_i |=> flags_r[6]) else $error("bus reset flag not set");
    a_sof_flag: assert property (
        sof_evt_i |=> flags_r[5]) else $error("frame start flag not set");
    for (genvar i = 0; i < 3; i++) begin : g_ep_flag
        a_ep_done_flag: assert property (
            ep_done_i[i] |=> flags_r[i]) else $error("endpoint done flag not set");
    end
    a_ep3_dma_flag: assert property (
        ep_done_i[3] && dma_bus.busy |=> flags_r[3]) else $error("endpoint 3 flag not set");
    a_ep3_no_dma: assert property (
        ep_done_i[3] && !dma_bus.busy && !flags_r[3]
        |=> !flags_r[3]) else $error("endpoint 3 flag without DMA");
    a_frame_holds: assert property (
        !sof_evt_i |=> $stable(frame_r)) else $error("frame changed without frame start");

    // Output enable trails the read strobe by one edge
    a_oe_on_read: assert property (
        !cs_n_i && !rd_n_i |=> data_oe_o) else $error("output enable missing on read");
    a_oe_off_idle: assert property (
        cs_n_i || rd_n_i |=> !data_oe_o) else $error("output enable without read");
    a_match_on: assert property (
        token_addr_i == dev_addr_r |=> addr_match_o) else $error("own address not matched");
    a_match_off: assert property (
        token_addr_i != dev_addr_r |=> !addr_match_o) else $error("foreign address matched");
    a_done_one_cycle: assert property (
        dma_bus.done |=> !dma_bus.done) else $error("DMA done held too long");
endmodule
